/* File: design/rsq_pkg.sv */
// Constants, field layout and state type for the reset sequencer.
// Assumes a 40 MHz system clock; the Wishbone master uses byte addresses.
package rsq_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int POR_DELAY_NS = 100000;
    localparam int POR_DELAY_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_HOLD_CYC = 4;

    localparam logic [7:0] ADR_RESET_SOURCE = 8'h00;
    localparam logic [7:0] ADR_MONITOR_CTL = 8'h04;

    localparam int SRC_PIN_BIT = 0;
    localparam int SRC_POR_BIT = 1;
    localparam int SRC_LVL_BIT = 2;
    localparam int SRC_MON0_BIT = 3;
    localparam int SRC_SW_BIT = 4;

    localparam int MON_LVL1_EN_BIT = 4;
    localparam int MON_STAT_BIT = 6;
    localparam int MON_EN_BIT = 7;

    localparam logic [7:0] PORT_LATCH_RST = 8'hff;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [3:0] WDT_CLK_DIV = 4'hc;

    typedef enum logic [2:0] {
        RSQ_SUPPLY_LOW,
        RSQ_POR_DELAY,
        RSQ_MON_HOLD,
        RSQ_SHORT_HOLD,
        RSQ_RUN
    } rsq_state_t;
endpackage : rsq_pkg

/* File: design/rsq_rst_sync.sv */
// Reset synchroniser: asynchronous assertion, two-flop synchronous release.
// Assumes req_i is glitch free (driven from a flop or a reset port).
`timescale 1ns/1ps
module rsq_rst_sync
(
    input wire logic clk_i,
    input wire logic req_i,
    output logic rst_o
);
    logic meta_r;
    logic hold_r;

    // Release waits two edges so no flop sees a metastable release
    always_ff @(posedge clk_i or posedge req_i)
    begin
        if (req_i)
        begin
            meta_r <= 1'b1;
            hold_r <= 1'b1;
        end
        else
        begin
            meta_r <= 1'b0;
            hold_r <= meta_r;
        end
    end

    assign rst_o = hold_r;
endmodule : rsq_rst_sync

/* File: design/rsq_sequencer.sv */
// Central reset sequencer: power-on delay, monitor, pin and software resets.
// Assumes rst_i is the power-on reset, inputs synchronous to clk_i,
// and a classic Wishbone master on the register port.
`timescale 1ns/1ps
module rsq_sequencer
    import rsq_pkg::*;
#(
    parameter int POR_CYC = POR_DELAY_CYC,
    parameter int CNT_W = 16
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic supply_good_i,
    input wire logic mon0_low_i,
    input wire logic rst_pin_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic core_rst_o,
    output logic rst_pin_o,
    output logic rst_pin_oen_o,
    output logic [7:0] port_latch_o,
    output logic port_od_o,
    output logic weak_pullup_en_o,
    output logic [15:0] reset_vector_o,
    output logic clk_int_sel_o,
    output logic wdt_en_o,
    output logic [3:0] wdt_div_o,
    output logic mon0_en_o,
    output logic mon0_sel_o,
    output logic mon1_en_o
);
    localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYC - 1);
    localparam logic [2:0] SHORT_LAST = 3'(SHORT_HOLD_CYC - 1);

    rsq_state_t state_r;
    logic [CNT_W-1:0] por_cnt_r;
    logic [2:0] hold_cnt_r;
    logic req_r;
    logic pin_drive_r;
    logic por_flag_r;
    logic pin_flag_r;
    logic lvl_flag_r;
    logic mon0_flag_r;
    logic sw_flag_r;
    logic mon0_en_r;
    logic mon0_sel_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [7:0] port_latch_r;
    logic [15:0] vector_r;
    logic [3:0] wdt_div_r;
    logic ctl_r;
    logic core_rst;

    logic bus_req;
    logic wr_src;
    logic wr_mon;
    logic lvl_trip;
    logic mon0_trip;
    logic pin_req;
    logic sw_req;
    logic leave_run;
    logic [31:0] rd_nxt;

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr_src = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADR_RESET_SOURCE);
    assign wr_mon = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADR_MONITOR_CTL);

    // Level monitor has no enable at all
    assign lvl_trip = ~supply_good_i;
    assign mon0_trip = mon0_en_r & mon0_sel_r & mon0_low_i;
    // Pin is only an input while this block is not pulling it low
    assign pin_req = ~rst_pin_i & ~pin_drive_r;
    assign sw_req = wr_src & wb_dat_i[SRC_SW_BIT];
    assign leave_run = (state_r == RSQ_RUN) & (lvl_trip | mon0_trip | pin_req | sw_req);

    // Sequencing state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= RSQ_SUPPLY_LOW;
        end
        else
        begin
            case (state_r)
                RSQ_SUPPLY_LOW:
                begin
                    if (supply_good_i)
                    begin
                        state_r <= RSQ_POR_DELAY;
                    end
                end
                RSQ_POR_DELAY:
                begin
                    if (!supply_good_i)
                    begin
                        state_r <= RSQ_SUPPLY_LOW;
                    end
                    else if (por_cnt_r == POR_LAST)
                    begin
                        state_r <= RSQ_RUN;
                    end
                end
                RSQ_RUN:
                begin
                    if (lvl_trip || mon0_trip)
                    begin
                        state_r <= RSQ_MON_HOLD;
                    end
                    else if (pin_req || sw_req)
                    begin
                        state_r <= RSQ_SHORT_HOLD;
                    end
                end
                RSQ_MON_HOLD:
                begin
                    // No power-on delay after a monitor reset
                    if (supply_good_i && !mon0_trip)
                    begin
                        state_r <= RSQ_RUN;
                    end
                end
                RSQ_SHORT_HOLD:
                begin
                    if (lvl_trip)
                    begin
                        state_r <= RSQ_MON_HOLD;
                    end
                    else if (hold_cnt_r == SHORT_LAST && rst_pin_i)
                    begin
                        state_r <= RSQ_RUN;
                    end
                end
                default:
                begin
                    state_r <= RSQ_SUPPLY_LOW;
                end
            endcase
        end
    end

    // Power-on delay counter, untouched by non power-on resets
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !supply_good_i || state_r != RSQ_POR_DELAY)
        begin
            por_cnt_r <= '0;
        end
        else if (por_cnt_r != POR_LAST)
        begin
            por_cnt_r <= por_cnt_r + 1'b1;
        end
    end

    // Short hold for pin and software resets
    always_ff @(posedge clk_i)
    begin
        if (rst_i || state_r != RSQ_SHORT_HOLD)
        begin
            hold_cnt_r <= '0;
        end
        else if (hold_cnt_r != SHORT_LAST)
        begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
        end
    end

    // Registered request keeps glitches off the asynchronous set
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            req_r <= 1'b1;
            pin_drive_r <= 1'b1;
        end
        else
        begin
            req_r <= (state_r != RSQ_RUN) | leave_run;
            // A level drop inside a short hold must pull the pin as well
            pin_drive_r <= (state_r == RSQ_SUPPLY_LOW) | (state_r == RSQ_POR_DELAY)
                | (state_r == RSQ_MON_HOLD)
                | ((state_r == RSQ_RUN) & mon0_trip)
                | (((state_r == RSQ_RUN) | (state_r == RSQ_SHORT_HOLD)) & lvl_trip);
        end
    end

    rsq_rst_sync u_sync
    (
        .clk_i(clk_i),
        .req_i(rst_i | req_r),
        .rst_o(core_rst)
    );

    // Reset cause flags
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            por_flag_r <= 1'b0;
            pin_flag_r <= 1'b0;
            lvl_flag_r <= 1'b0;
            mon0_flag_r <= 1'b0;
            sw_flag_r <= 1'b0;
        end
        else if (state_r == RSQ_POR_DELAY && por_cnt_r == POR_LAST && supply_good_i)
        begin
            por_flag_r <= 1'b1;
            // Other causes read as zero here, allowed to be anything
            pin_flag_r <= 1'b0;
            lvl_flag_r <= 1'b0;
            mon0_flag_r <= 1'b0;
            sw_flag_r <= 1'b0;
        end
        else if (leave_run)
        begin
            por_flag_r <= 1'b0;
            lvl_flag_r <= lvl_trip;
            mon0_flag_r <= ~lvl_trip & mon0_trip;
            pin_flag_r <= ~lvl_trip & ~mon0_trip & pin_req;
            sw_flag_r <= ~lvl_trip & ~mon0_trip & ~pin_req & sw_req;
        end
    end

    // Primary monitor enable: only power-on forces it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mon0_en_r <= 1'b1;
        end
        else if (wr_mon)
        begin
            mon0_en_r <= wb_dat_i[MON_EN_BIT];
        end
    end

    // Source select is an ordinary register, defaulted by every reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i || core_rst)
        begin
            mon0_sel_r <= 1'b1;
        end
        else if (wr_src)
        begin
            mon0_sel_r <= wb_dat_i[SRC_POR_BIT];
        end
    end

    // Wishbone slave, one wait state; unmapped reads return zero
    always_comb
    begin
        rd_nxt = '0;
        if (wb_adr_i == ADR_RESET_SOURCE)
        begin
            rd_nxt[SRC_PIN_BIT] = pin_flag_r;
            rd_nxt[SRC_POR_BIT] = por_flag_r;
            rd_nxt[SRC_LVL_BIT] = lvl_flag_r;
            rd_nxt[SRC_MON0_BIT] = mon0_flag_r;
            rd_nxt[SRC_SW_BIT] = sw_flag_r;
        end
        else if (wb_adr_i == ADR_MONITOR_CTL)
        begin
            rd_nxt[MON_EN_BIT] = mon0_en_r;
            rd_nxt[MON_STAT_BIT] = supply_good_i;
            rd_nxt[MON_LVL1_EN_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end
        else
        begin
            ack_r <= bus_req;
            dat_r <= bus_req ? rd_nxt : '0;
        end
    end

    // Defaults handed to core, clocking, watchdog and ports
    always_ff @(posedge clk_i)
    begin
        if (rst_i || core_rst)
        begin
            port_latch_r <= PORT_LATCH_RST;
            vector_r <= RESET_VECTOR;
            wdt_div_r <= WDT_CLK_DIV;
            ctl_r <= 1'b1;
        end
    end

    // Data memory has no reset path here; core reset reloads the program counter
    assign core_rst_o = core_rst;
    assign rst_pin_o = 1'b0;
    assign rst_pin_oen_o = ~pin_drive_r;
    assign port_latch_o = port_latch_r;
    assign port_od_o = ctl_r;
    assign weak_pullup_en_o = ctl_r;
    assign reset_vector_o = vector_r;
    assign clk_int_sel_o = ctl_r;
    assign wdt_en_o = ctl_r;
    assign wdt_div_o = wdt_div_r;
    assign mon0_en_o = mon0_en_r;
    assign mon0_sel_o = mon0_sel_r;
    assign mon1_en_o = ctl_r;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
endmodule : rsq_sequencer

/* File: sim/rsq_core_model.sv */
// Core model held in reset by the sequencer: program counter only.
// Assumes core_rst_i and reset_vector_i come straight from the sequencer.
`timescale 1ns/1ps
module rsq_core_model
    import rsq_pkg::*;
(
    input wire logic clk_i,
    input wire logic core_rst_i,
    input wire logic [15:0] reset_vector_i,
    output logic [15:0] pc_o
);
    // Halted and reloaded while held; stack and memory not modelled
    // Memory after power-up is never relied on
    always_ff @(posedge clk_i)
    begin
        if (core_rst_i)
            pc_o <= reset_vector_i;
        else
            pc_o <= pc_o + 16'h0001;
    end
endmodule : rsq_core_model

/* File: sim/rsq_checker.sv */
// Assertions on the reset sequencer top module ports.
// Assumes one clock domain, rst_i being the power-on reset.
`timescale 1ns/1ps
module rsq_checker
#(
    parameter int POR_CYC = 8
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic supply_good_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic core_rst_o,
    input wire logic rst_pin_oen_o,
    input wire logic [7:0] port_latch_o,
    input wire logic port_od_o,
    input wire logic weak_pullup_en_o,
    input wire logic [15:0] reset_vector_o,
    input wire logic clk_int_sel_o,
    input wire logic wdt_en_o,
    input wire logic [3:0] wdt_div_o,
    input wire logic mon0_en_o,
    input wire logic mon1_en_o
);
    logic [5:0] good_cnt_r;
    logic por_pend_r;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Saturates, so a long run never wraps back into the hold window
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !supply_good_i)
            good_cnt_r <= 6'h00;
        else if (good_cnt_r != 6'h3f)
            good_cnt_r <= good_cnt_r + 6'h01;
    end
    // Pending until the first release after power-on, whatever follows
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            por_pend_r <= 1'b1;
        else if (!core_rst_o)
            por_pend_r <= 1'b0;
    end
    sequence s_mon_wr;
        wb_ack_o && wb_we_i && wb_adr_i == 8'h04;
    endsequence
    sequence s_por_exit;
        por_pend_r && $fell(core_rst_o);
    endsequence
    AST_POR_HOLD: assert property (por_pend_r && good_cnt_r <= POR_CYC |-> core_rst_o)
        else $error("core released inside power-on delay");
    AST_POR_REL: assert property (por_pend_r && good_cnt_r == POR_CYC + 4 |-> !core_rst_o)
        else $error("core not released after power-on delay");
    AST_SUPPLY: assert property (!supply_good_i |=> core_rst_o)
        else $error("core runs with supply low");
    AST_PIN_LOW: assert property (!supply_good_i |=> !rst_pin_oen_o)
        else $error("pin not driven with supply low");
    AST_PIN_HOLD: assert property (!rst_pin_oen_o |-> core_rst_o)
        else $error("pin driven outside reset");
    AST_PORTS: assert property (port_latch_o == 8'hff && port_od_o)
        else $error("port latch default wrong");
    AST_PULLUP: assert property (weak_pullup_en_o)
        else $error("pull-ups off");
    AST_VECTOR: assert property (reset_vector_o == 16'h0000)
        else $error("start address wrong");
    AST_CLKSEL: assert property (clk_int_sel_o)
        else $error("internal oscillator not selected");
    AST_WDT: assert property (wdt_en_o && wdt_div_o == 4'hc)
        else $error("watchdog default wrong");
    AST_LVL: assert property (mon1_en_o)
        else $error("level monitor disabled");
    AST_MON0: assert property ($changed(mon0_en_o) |-> s_mon_wr)
        else $error("primary monitor enable moved by reset");
    AST_POR_MON: assert property (s_por_exit |-> mon0_en_o && mon1_en_o)
        else $error("monitors off after power-on");
endmodule : rsq_checker
bind rsq_sequencer rsq_checker #(.POR_CYC(POR_CYC)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .supply_good_i(supply_good_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_ack_o(wb_ack_o), .core_rst_o(core_rst_o), .rst_pin_oen_o(rst_pin_oen_o),
    .port_latch_o(port_latch_o), .port_od_o(port_od_o), .weak_pullup_en_o(weak_pullup_en_o),
    .reset_vector_o(reset_vector_o), .clk_int_sel_o(clk_int_sel_o), .wdt_en_o(wdt_en_o),
    .wdt_div_o(wdt_div_o), .mon0_en_o(mon0_en_o), .mon1_en_o(mon1_en_o));

/* File: sim/testbench.sv */
// Self-checking bench for the reset sequencer.
// Assumes a pull-up on the reset pin; bench drives the primary trip input.
`timescale 1ns/1ps
module testbench;
    typedef struct packed
    {
        logic [7:0] adr;
        logic we;
        logic [31:0] dat;
        logic [31:0] exp;
    } rsq_row_t;
    rsq_row_t rows [6] = '{'{8'h00, 1'b0, 32'h0, 32'h2}, '{8'h04, 1'b0, 32'h0, 32'hd0},
        '{8'h08, 1'b1, 32'hff, 32'h0}, '{8'h08, 1'b0, 32'h0, 32'h0},
        '{8'h04, 1'b1, 32'h0, 32'h0}, '{8'h04, 1'b0, 32'h0, 32'h50}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic good = 1'b0;
    logic ext_n = 1'b1;
    logic m0low = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] q, rdat;
    logic ack, core, pin_o, oen, od, pu, csel, wen, m0en, m0sel, m1en, pin_w;
    logic [7:0] latch;
    logic [15:0] vec, pc;
    logic [3:0] wdiv;
    int n_fail = 0;
    int n_compared = 0;
    // Open-drain pin: block pulls low, otherwise the external side decides
    assign pin_w = oen ? ext_n : pin_o;
    always #12.5 clk_i = ~clk_i;
    rsq_sequencer #(.POR_CYC(8)) uut (.clk_i(clk_i), .rst_i(rst_i), .supply_good_i(good),
        .mon0_low_i(m0low), .rst_pin_i(pin_w), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .core_rst_o(core), .rst_pin_o(pin_o), .rst_pin_oen_o(oen), .port_latch_o(latch),
        .port_od_o(od), .weak_pullup_en_o(pu), .reset_vector_o(vec), .clk_int_sel_o(csel),
        .wdt_en_o(wen), .wdt_div_o(wdiv), .mon0_en_o(m0en), .mon0_sel_o(m0sel),
        .mon1_en_o(m1en));
    rsq_core_model u_core (.clk_i(clk_i), .core_rst_i(core), .reset_vector_i(vec), .pc_o(pc));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Request stands until ack is sampled high at a rising edge; watchdog ends a hang
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task wait_core(input logic lvl);
        int i;
        i = 0;
        while (core !== lvl && i < 200)
        begin
            @(posedge clk_i);
            #1;
            i++;
        end
        chk("core_rst", core, lvl);
    endtask : wait_core
    task test_done();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (3000) @(posedge clk_i);
        n_fail++;
        test_done();
    end
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        good <= 1'b1;
        wait_core(1'b0);
        chk("pc", pc, 16'h0000);
        chk("defaults", {latch, od, pu, csel, wen, wdiv}, 16'hfffc);
        for (int i = 0; i < 6; i++)
        begin
            wb(rows[i].adr, rows[i].we, rows[i].dat);
            if (!rows[i].we)
                chk("row", q, rows[i].exp);
        end
        wb(8'h00, 1'b1, 32'h10);
        chk("sw hold", {core, oen}, 2'b11);
        wait_core(1'b0);
        wb(8'h00, 1'b0, 32'h0);
        chk("sw flags", q, 32'h10);
        chk("sel", m0sel, 1'b1);
        wb(8'h04, 1'b0, 32'h0);
        chk("mon kept", q, 32'h50);
        @(posedge clk_i);
        ext_n <= 1'b0;
        repeat (2) @(posedge clk_i);
        ext_n <= 1'b1;
        wait_core(1'b1);
        wait_core(1'b0);
        wb(8'h00, 1'b0, 32'h0);
        chk("pin flags", q, 32'h01);
        repeat (70) @(posedge clk_i);
        good <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("drop", {core, oen}, 2'b10);
        @(posedge clk_i);
        good <= 1'b1;
        wait_core(1'b0);
        wb(8'h00, 1'b0, 32'h0);
        chk("drop flags", q, 32'h04);
        m0low <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("mon0 off", core, 1'b0);
        wb(8'h04, 1'b1, 32'h80);
        repeat (2) @(posedge clk_i);
        chk("mon0 trip", {core, oen}, 2'b10);
        m0low <= 1'b0;
        wait_core(1'b0);
        wb(8'h00, 1'b0, 32'h0);
        chk("mon0 flags", q, 32'h08);
        wb(8'h04, 1'b1, 32'h0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        good <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        good <= 1'b1;
        repeat (4) @(posedge clk_i);
        good <= 1'b0;
        @(posedge clk_i);
        good <= 1'b1;
        repeat (10) @(posedge clk_i);
        #1;
        chk("restart hold", core, 1'b1);
        wait_core(1'b0);
        wb(8'h04, 1'b0, 32'h0);
        chk("por mon", q, 32'hd0);
        test_done();
    end
endmodule : testbench
